// ===== hdl/hadc_pkg.sv
// package for the host address decoder and configuration access block
package hadc_pkg;
  localparam logic [35:0] DOS_END = 36'h00007FFFF;
  localparam logic [35:0] ISA_WIN_END = 36'h00009FFFF;
  localparam logic [35:0] VIDEO_END = 36'h0000BFFFF;
  localparam logic [35:0] ADDIN_END = 36'h0000DFFFF;
  localparam logic [35:0] EXTBIOS_END = 36'h0000EFFFF;
  localparam logic [35:0] SYSBIOS_END = 36'h0000FFFFF;
  localparam logic [35:0] HOLE_BASE = 36'h000F00000;
  localparam logic [35:0] HOLE_END = 36'h000FFFFFF;
  localparam logic [35:0] TOP_MAX = 36'h300000000;
  localparam logic [35:0] TOP_EXT_MGMT = 36'h010000000;
  localparam logic [35:0] FOUR_GB = 36'h100000000;
  localparam logic [35:0] HIGH_FW_BASE = 36'h0FFE00000;
  localparam logic [35:0] IRQ_ROUTER_BASE = 36'h0FEC00000;
  localparam logic [35:0] IRQ_ROUTER_END = 36'h0FEC0FFFF;
  localparam logic [15:0] CFG_SELECT_OFS = 16'h0CF8;
  localparam logic [15:0] CFG_WINDOW_OFS = 16'h0CFC;
  localparam logic [31:0] CFG_SELECT_RST = 32'h00000000;
  localparam logic [31:0] CFG_SELECT_MASK = 32'h80FFFFFC;
  localparam int BUS_LSB = 16;
  localparam int DEV_LSB = 11;
  localparam int FUNC_LSB = 8;
  localparam int REG_LSB = 2;
  localparam int IDSEL_LSB = 11;
  localparam logic [7:0] ATTR_RST = 8'h00;
  localparam logic [3:0] EXT_RST = 4'h0;
  localparam logic [1:0] SYS_RST = 2'h0;
  localparam logic [4:0] DEV_HOST_BRIDGE = 5'h00;
  localparam logic [4:0] DEV_USB = 5'h1D;
  localparam logic [4:0] DEV_SEC_BRIDGE = 5'h1E;
  localparam logic [4:0] DEV_IDE = 5'h1F;
  localparam logic [4:0] DEV_GRAPHICS = 5'h0C;

  typedef enum logic [1:0] {
    HADC_TGT_MEM = 2'b00,
    HADC_TGT_PCI = 2'b01,
    HADC_TGT_DROP = 2'b10
  } hadc_target_t;

  // memory request from the host bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [35:0] addr;
    logic from_pci;
  } hadc_mem_req_t;

  // io request from the host bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } hadc_io_req_t;

  // programmable routing attributes
  typedef struct packed {
    logic isa_win_pci;
    logic [7:0] addin_rd;
    logic [7:0] addin_wr;
    logic [3:0] ext_rd;
    logic [3:0] ext_wr;
    logic sys_rd;
    logic sys_wr;
    logic hole_pci;
    logic ext_mgmt_en;
    logic mgmt_open;
    logic [35:0] installed_top;
  } hadc_attr_t;

  // configuration cycle toward the pci side
  typedef struct packed {
    logic valid;
    logic write;
    logic type1;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
    logic [4:0] regnum;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [20:0] idsel;
  } hadc_cfg_cycle_t;
endpackage : hadc_pkg

// ===== hdl/hadc_mem_route.sv
// combinational memory address router
`timescale 1ns/1ps
module hadc_mem_route (
  input wire hadc_pkg::hadc_mem_req_t req,
  input wire hadc_pkg::hadc_attr_t attr,
  input wire logic mgmt_mode,
  output hadc_pkg::hadc_target_t target,
  output logic mgmt_region,
  output logic uncached
);
  import hadc_pkg::*;

  logic [2:0] seg8;
  logic [1:0] seg4;
  logic rd_mem;
  logic wr_mem;
  logic [35:0] top;

  always_comb begin
    seg8 = req.addr[16:14];
    seg4 = req.addr[15:14];
    rd_mem = 1'b0;
    wr_mem = 1'b0;
    target = HADC_TGT_PCI;
    mgmt_region = 1'b0;
    uncached = 1'b0;
    // extended management ram caps usable memory
    top = attr.ext_mgmt_en ? TOP_EXT_MGMT : TOP_MAX;
    if (attr.installed_top < top) begin
      top = attr.installed_top;
    end
    if (req.addr <= DOS_END) begin
      target = HADC_TGT_MEM;
    end else if (req.addr <= ISA_WIN_END) begin
      target = attr.isa_win_pci ? HADC_TGT_PCI : HADC_TGT_MEM;
    end else if (req.addr <= VIDEO_END) begin
      mgmt_region = 1'b1;
      uncached = 1'b1;
      // ram only when in management mode or opened by configuration
      target = (mgmt_mode || attr.mgmt_open) ? HADC_TGT_MEM : HADC_TGT_PCI;
    end else if (req.addr <= SYSBIOS_END) begin
      if (req.addr <= ADDIN_END) begin
        rd_mem = attr.addin_rd[seg8];
        wr_mem = attr.addin_wr[seg8];
      end else if (req.addr <= EXTBIOS_END) begin
        rd_mem = attr.ext_rd[seg4];
        wr_mem = attr.ext_wr[seg4];
        mgmt_region = attr.ext_mgmt_en;
      end else begin
        rd_mem = attr.sys_rd;
        wr_mem = attr.sys_wr;
        mgmt_region = attr.ext_mgmt_en;
      end
      // reads and writes follow separate attributes while shadowing
      target = (req.write ? wr_mem : rd_mem) ? HADC_TGT_MEM : HADC_TGT_PCI;
      // pci masters never reach the host bus through a shadowed block
      if (req.from_pci && (req.write ? wr_mem : rd_mem)) begin
        target = HADC_TGT_DROP;
      end
    end else if (req.addr >= HOLE_BASE && req.addr <= HOLE_END && attr.hole_pci) begin
      target = HADC_TGT_PCI;
    end else if ((req.addr >= HIGH_FW_BASE && req.addr < FOUR_GB)
        || (req.addr >= IRQ_ROUTER_BASE && req.addr <= IRQ_ROUTER_END)) begin
      // boot fetch must reach firmware even when installed memory covers it
      target = HADC_TGT_PCI;
    end else if (req.addr < top) begin
      target = HADC_TGT_MEM;
    end else if (req.addr < FOUR_GB) begin
      // space between installed memory and 4 GB is a pci-side decode
      target = HADC_TGT_PCI;
    end else begin
      target = HADC_TGT_PCI;
    end
  end
endmodule : hadc_mem_route

// ===== hdl/hadc_top.sv
// host address decode and configuration access, top level
// How it works
// - low 512 KB always main memory
// - 080000h window selectable pci or memory
// - 0A0000h range to graphics, management default
// - eight 16 KB segments with own attributes
// - four 16 KB blocks, memory or pci
// - 0F0000h block defaults to pci, shadowable
// - above 1 MB memory, 1 MB hole at 15 MB optional
// - top 12 GB, 256 MB with extension
// - above installed, below 4 GB goes pci
// - top 2 MB below 4 GB firmware
// - router block at FEC00000h, 64 KB
// - reads and writes routed independently when shadowing
// - pci masters to shadowed blocks dropped
// - 0A0000h management ram visible only in mode or when opened by configuration, uncached
// - selector port 0CF8h, window port 0CFCh
// - select first, window access then transfers
// - window byte enables select accessed bytes
// - only full dword selector accesses recognised
// - selector fields: bus, device, function, register
// - one AD line asserted as chip select
// - fixed device numbers on buses 0, 1
`timescale 1ns/1ps
module hadc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire hadc_pkg::hadc_mem_req_t mem_req,
  input wire logic mgmt_mode_pin,
  input wire logic mgmt_open_in,
  input wire logic isa_win_pci_in,
  input wire logic [7:0] addin_rd_in,
  input wire logic [7:0] addin_wr_in,
  input wire logic [3:0] ext_rd_in,
  input wire logic [3:0] ext_wr_in,
  input wire logic sys_rd_in,
  input wire logic sys_wr_in,
  input wire logic hole_pci_in,
  input wire logic ext_mgmt_en_in,
  input wire logic [35:0] installed_top_in,
  input wire logic attr_load,
  input wire hadc_pkg::hadc_io_req_t io_req,
  input wire logic cfg_done,
  input wire logic [31:0] cfg_rdata,
  output hadc_pkg::hadc_target_t mem_target,
  output logic mem_valid,
  output logic mem_uncached,
  output logic mem_mgmt_region,
  output hadc_pkg::hadc_cfg_cycle_t cfg_cycle,
  output logic io_fwd_valid,
  output logic io_ack,
  output logic [31:0] io_rdata
);
  import hadc_pkg::*;

  typedef enum logic [1:0] {
    HADC_IDLE = 2'b00,
    HADC_CFG_WAIT = 2'b01,
    HADC_ACK = 2'b10
  } hadc_state_t;

  // management mode pin is asynchronous to the core clock
  logic mgmt_sync1_reg;
  logic mgmt_sync2_reg;
  logic mgmt_sync1_next;
  logic mgmt_sync2_next;

  hadc_attr_t attr_reg;
  hadc_attr_t attr_next;
  hadc_target_t route_tgt;
  logic route_mgmt;
  logic route_unc;
  hadc_target_t mem_target_reg;
  hadc_target_t mem_target_next;
  logic mem_valid_reg;
  logic mem_valid_next;
  logic mem_unc_reg;
  logic mem_unc_next;
  logic mem_mgmt_reg;
  logic mem_mgmt_next;

  logic [31:0] sel_reg;
  logic [31:0] sel_next;
  hadc_state_t state_reg;
  hadc_state_t state_next;
  hadc_cfg_cycle_t cyc_reg;
  hadc_cfg_cycle_t cyc_next;
  logic fwd_reg;
  logic fwd_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic sel_hit;
  logic win_hit;
  logic full_dw;
  logic [20:0] idsel_dec;
  logic [31:0] be_mask;
  logic [31:0] rd_mask;

  always_comb begin
    mgmt_sync1_next = mgmt_mode_pin;
    mgmt_sync2_next = mgmt_sync1_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mgmt_sync1_reg <= 1'b0;
      mgmt_sync2_reg <= 1'b0;
    end else begin
      mgmt_sync1_reg <= mgmt_sync1_next;
      mgmt_sync2_reg <= mgmt_sync2_next;
    end
  end

  // attribute capture; defaults forward legacy windows to pci, keep the hole as memory and hide management ram
  always_comb begin
    attr_next = attr_reg;
    if (attr_load) begin
      attr_next.isa_win_pci = isa_win_pci_in;
      attr_next.addin_rd = addin_rd_in;
      attr_next.addin_wr = addin_wr_in;
      attr_next.ext_rd = ext_rd_in;
      attr_next.ext_wr = ext_wr_in;
      attr_next.sys_rd = sys_rd_in;
      attr_next.sys_wr = sys_wr_in;
      attr_next.hole_pci = hole_pci_in;
      attr_next.ext_mgmt_en = ext_mgmt_en_in;
      attr_next.mgmt_open = mgmt_open_in;
      attr_next.installed_top = installed_top_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      attr_reg.isa_win_pci <= 1'b1;
      attr_reg.addin_rd <= ATTR_RST;
      attr_reg.addin_wr <= ATTR_RST;
      attr_reg.ext_rd <= EXT_RST;
      attr_reg.ext_wr <= EXT_RST;
      attr_reg.sys_rd <= SYS_RST[0];
      attr_reg.sys_wr <= SYS_RST[1];
      attr_reg.hole_pci <= 1'b0;
      attr_reg.ext_mgmt_en <= 1'b0;
      attr_reg.mgmt_open <= 1'b0;
      attr_reg.installed_top <= TOP_MAX;
    end else begin
      attr_reg <= attr_next;
    end
  end

  hadc_mem_route u_route (
    .req(mem_req),
    .attr(attr_reg),
    .mgmt_mode(mgmt_sync2_reg),
    .target(route_tgt),
    .mgmt_region(route_mgmt),
    .uncached(route_unc)
  );

  // routing answer is registered one cycle after the request
  always_comb begin
    mem_valid_next = mem_req.valid;
    mem_target_next = mem_req.valid ? route_tgt : HADC_TGT_MEM;
    mem_unc_next = mem_req.valid & route_unc;
    mem_mgmt_next = mem_req.valid & route_mgmt;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_valid_reg <= 1'b0;
      mem_target_reg <= HADC_TGT_MEM;
      mem_unc_reg <= 1'b0;
      mem_mgmt_reg <= 1'b0;
    end else begin
      mem_valid_reg <= mem_valid_next;
      mem_target_reg <= mem_target_next;
      mem_unc_reg <= mem_unc_next;
      mem_mgmt_reg <= mem_mgmt_next;
    end
  end

  // one-hot chip select over AD[31:11], bus 0 only; others go type 1
  generate
    for (genvar i = 0; i < 21; i++) begin : g_idsel
      assign idsel_dec[i] = (sel_reg[BUS_LSB +: 8] == 8'h00) && (sel_reg[DEV_LSB +: 5] == 5'(i));
    end
  endgenerate

  generate
    for (genvar b = 0; b < 4; b++) begin : g_be
      assign be_mask[b*8 +: 8] = io_req.be[b] ? 8'hFF : 8'h00;
      // read masking uses the latched enables, the host bus may have moved on
      assign rd_mask[b*8 +: 8] = cyc_reg.be[b] ? 8'hFF : 8'h00;
    end
  endgenerate

  always_comb begin
    sel_hit = io_req.valid && (io_req.addr == CFG_SELECT_OFS);
    win_hit = io_req.valid && (io_req.addr == CFG_WINDOW_OFS);
    full_dw = (io_req.be == 4'hF);
    state_next = state_reg;
    sel_next = sel_reg;
    cyc_next = cyc_reg;
    cyc_next.valid = 1'b0;
    fwd_next = 1'b0;
    ack_next = 1'b0;
    rdata_next = rdata_reg;
    case (state_reg)
      HADC_IDLE: begin
        if (sel_hit && full_dw) begin
          ack_next = 1'b1;
          state_next = HADC_ACK;
          if (io_req.write) begin
            sel_next = io_req.wdata & CFG_SELECT_MASK;
          end else begin
            rdata_next = sel_reg;
          end
        end else if (win_hit && sel_reg[31]) begin
          // window transfer targets the register latched in the selector
          cyc_next.valid = 1'b1;
          cyc_next.write = io_req.write;
          cyc_next.bus = sel_reg[BUS_LSB +: 8];
          cyc_next.dev = sel_reg[DEV_LSB +: 5];
          cyc_next.func = sel_reg[FUNC_LSB +: 3];
          cyc_next.regnum = sel_reg[REG_LSB +: 5];
          cyc_next.type1 = (sel_reg[BUS_LSB +: 8] != 8'h00);
          cyc_next.be = io_req.be;
          cyc_next.wdata = io_req.wdata & be_mask;
          cyc_next.idsel = idsel_dec;
          state_next = HADC_CFG_WAIT;
        end else if (io_req.valid) begin
          // narrow selector accesses and everything else pass on as io
          fwd_next = 1'b1;
        end
      end
      HADC_CFG_WAIT: begin
        if (cfg_done) begin
          ack_next = 1'b1;
          rdata_next = cyc_reg.write ? 32'h00000000 : (cfg_rdata & rd_mask);
          state_next = HADC_ACK;
        end
      end
      HADC_ACK: begin
        state_next = HADC_IDLE;
      end
      default: begin
        state_next = HADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= HADC_IDLE;
      sel_reg <= CFG_SELECT_RST;
      cyc_reg <= '0;
      fwd_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      cyc_reg <= cyc_next;
      fwd_reg <= fwd_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign mem_target = mem_target_reg;
  assign mem_valid = mem_valid_reg;
  assign mem_uncached = mem_unc_reg;
  assign mem_mgmt_region = mem_mgmt_reg;
  assign cfg_cycle = cyc_reg;
  assign io_fwd_valid = fwd_reg;
  assign io_ack = ack_reg;
  assign io_rdata = rdata_reg;

  sequence win_taken_s;
    state_reg == HADC_IDLE && win_hit && sel_reg[31];
  endsequence

  dos_to_memory_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_req.valid && mem_req.addr <= DOS_END |=> mem_valid && mem_target == HADC_TGT_MEM)
    else $error("low region not routed to memory");
  isa_window_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_req.valid && mem_req.addr > DOS_END && mem_req.addr <= ISA_WIN_END && attr_reg.isa_win_pci
    |=> mem_target == HADC_TGT_PCI)
    else $error("isa window selection ignored");
  mgmt_hidden_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_req.valid && mem_req.addr > ISA_WIN_END && mem_req.addr <= VIDEO_END && !mgmt_sync2_reg
    && !attr_reg.mgmt_open |=> mem_target == HADC_TGT_PCI && mem_uncached)
    else $error("management ram visible outside mode");
  sys_default_pci_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_req.valid && mem_req.addr > EXTBIOS_END && mem_req.addr <= SYSBIOS_END && !attr_reg.sys_rd
    && !mem_req.write && !mem_req.from_pci |=> mem_target == HADC_TGT_PCI)
    else $error("disabled firmware block not sent to pci");
  shadow_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_req.valid && mem_req.from_pci && mem_req.addr > VIDEO_END && mem_req.addr <= ADDIN_END
    && mem_req.write && attr_reg.addin_wr[mem_req.addr[16:14]] |=> mem_target == HADC_TGT_DROP)
    else $error("pci access to shadowed block reached host");
  narrow_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == HADC_IDLE && sel_hit && !full_dw |=> io_fwd_valid && $stable(sel_reg))
    else $error("narrow selector access not forwarded");
  select_readback_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == HADC_IDLE && sel_hit && full_dw && io_req.write ##1 (!sel_hit) [*3]
    ##1 (state_reg == HADC_IDLE && sel_hit && full_dw && !io_req.write)
    |=> io_ack && io_rdata == ($past(io_req.wdata, 5) & CFG_SELECT_MASK))
    else $error("selector does not read back");
  cfg_fields_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    win_taken_s |=> cfg_cycle.valid && cfg_cycle.dev == $past(sel_reg[15:11])
    && cfg_cycle.regnum == $past(sel_reg[6:2]) && cfg_cycle.be == $past(io_req.be))
    else $error("configuration cycle fields wrong");
  idsel_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_cycle.valid && !cfg_cycle.type1 && cfg_cycle.dev < 5'd21 |-> $onehot(cfg_cycle.idsel))
    else $error("chip select not one-hot");
endmodule : hadc_top

// ===== tb/hadc_pci_model.sv
// pci side configuration target answering config cycles
`timescale 1ns/1ps
module hadc_pci_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire hadc_pkg::hadc_cfg_cycle_t cfg_cycle,
  output logic cfg_done,
  output logic [31:0] cfg_rdata,
  output logic [7:0] n_seen
);
  import hadc_pkg::*;
  logic busy;
  logic slow;
  logic [3:0] wait_cnt;
  logic [4:0] reg_q;
  always_ff @(posedge core_clk) begin
    cfg_done <= 1'b0;
    // released data lines toggle so a stale value never looks valid
    cfg_rdata <= ~cfg_rdata;
    if (!rst_n) begin
      busy <= 1'b0;
      slow <= 1'b0;
      wait_cnt <= 4'h0;
      reg_q <= 5'h00;
      n_seen <= 8'h00;
      cfg_rdata <= 32'hFFFFFFFF;
    end else if (cfg_cycle.valid && !busy) begin
      busy <= 1'b1;
      // alternate prompt and slow answers
      wait_cnt <= slow ? 4'h5 : 4'h0;
      slow <= ~slow;
      reg_q <= cfg_cycle.regnum;
      n_seen <= n_seen + 8'h01;
    end else if (busy && wait_cnt == 4'h0) begin
      busy <= 1'b0;
      cfg_done <= 1'b1;
      cfg_rdata <= {24'hC3A55A, 3'h0, reg_q};
    end else if (busy) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule : hadc_pci_model

// ===== tb/tb_host_address_decode_cfg_access.sv
// self-checking bench for the host address decoder
`timescale 1ns/1ps
module tb_host_address_decode_cfg_access;
  import hadc_pkg::*;
  logic core_clk, rst_n, mgmt_mode_pin, mgmt_open_in, isa_win_pci_in, sys_rd_in, sys_wr_in;
  logic hole_pci_in, ext_mgmt_en_in, attr_load, cfg_done;
  logic [7:0] addin_rd_in, addin_wr_in, n_seen;
  logic [3:0] ext_rd_in, ext_wr_in;
  logic [35:0] installed_top_in;
  logic [31:0] cfg_rdata, io_rdata;
  hadc_mem_req_t mem_req;
  hadc_io_req_t io_req;
  hadc_target_t mem_target;
  hadc_cfg_cycle_t cfg_cycle;
  logic mem_valid, mem_uncached, mem_mgmt_region, io_fwd_valid, io_ack;
  int n_errors, tests_run;

  hadc_top dut (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req), .mgmt_mode_pin(mgmt_mode_pin),
    .mgmt_open_in(mgmt_open_in), .isa_win_pci_in(isa_win_pci_in), .addin_rd_in(addin_rd_in),
    .addin_wr_in(addin_wr_in), .ext_rd_in(ext_rd_in), .ext_wr_in(ext_wr_in), .sys_rd_in(sys_rd_in),
    .sys_wr_in(sys_wr_in), .hole_pci_in(hole_pci_in), .ext_mgmt_en_in(ext_mgmt_en_in),
    .installed_top_in(installed_top_in), .attr_load(attr_load), .io_req(io_req), .cfg_done(cfg_done),
    .cfg_rdata(cfg_rdata), .mem_target(mem_target), .mem_valid(mem_valid), .mem_uncached(mem_uncached),
    .mem_mgmt_region(mem_mgmt_region), .cfg_cycle(cfg_cycle), .io_fwd_valid(io_fwd_valid),
    .io_ack(io_ack), .io_rdata(io_rdata));
  hadc_pci_model partner (.core_clk(core_clk), .rst_n(rst_n), .cfg_cycle(cfg_cycle),
    .cfg_done(cfg_done), .cfg_rdata(cfg_rdata), .n_seen(n_seen));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_val(input string nm, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_tgt(input string nm, input hadc_target_t e, input hadc_target_t g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_tgt

  task automatic load_attr(input logic isa, input logic [7:0] ard, input logic [7:0] awr,
      input logic [3:0] erd, input logic [3:0] ewr, input logic srd, input logic swr,
      input logic hole, input logic extm, input logic open, input logic [35:0] top);
    @(negedge core_clk);
    {isa_win_pci_in, addin_rd_in, addin_wr_in, ext_rd_in, ext_wr_in} = {isa, ard, awr, erd, ewr};
    {sys_rd_in, sys_wr_in, hole_pci_in, ext_mgmt_en_in, mgmt_open_in} = {srd, swr, hole, extm, open};
    installed_top_in = top;
    attr_load = 1'b1;
    @(negedge core_clk);
    attr_load = 1'b0;
  endtask : load_attr

  // answer stands one cycle, seen at the next falling edge
  task automatic mem_chk(input logic [35:0] a, input logic wr, input logic fp, input hadc_target_t e,
      input logic mg);
    @(negedge core_clk);
    mem_req = '{valid: 1'b1, write: wr, addr: a, from_pci: fp};
    @(negedge core_clk);
    mem_req.valid = 1'b0;
    chk_bit("mem_valid", 1'b1, mem_valid);
    chk_tgt("mem_target", e, mem_target);
    chk_bit("mem_mgmt_region", mg, mem_mgmt_region);
    chk_bit("mem_uncached", mg, mem_uncached);
  endtask : mem_chk

  task automatic io_op(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd,
      output logic ack, output logic fwd, output logic [31:0] rd);
    int i;
    @(negedge core_clk);
    io_req = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: wd};
    @(negedge core_clk);
    io_req.valid = 1'b0;
    // a one-cycle ack or forward already stands at this edge
    ack = (io_ack === 1'b1);
    fwd = (io_fwd_valid === 1'b1);
    rd = io_rdata;
    for (i = 0; i < 20 && !ack && !fwd; i++) begin
      @(negedge core_clk);
      ack = (io_ack === 1'b1);
      fwd = (io_fwd_valid === 1'b1);
      rd = io_rdata;
    end
    if (!ack && !fwd) begin
      n_errors++;
      close_out();
    end
    repeat (2) @(negedge core_clk);
  endtask : io_op

  task automatic cfg_xfer(input logic wr, input logic [31:0] sel, input logic [3:0] be, input logic [31:0] wd,
      input logic t1, input logic [20:0] ids);
    logic ack, fwd;
    logic [31:0] rd, m;
    logic [7:0] cnt;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    io_op(1'b1, CFG_SELECT_OFS, 4'hF, sel, ack, fwd, rd);
    chk_bit("select ack", 1'b1, ack);
    io_op(1'b0, CFG_SELECT_OFS, 4'hF, 32'h0, ack, fwd, rd);
    chk_val("select readback", 36'(sel & CFG_SELECT_MASK), 36'(rd));
    cnt = n_seen;
    io_op(wr, CFG_WINDOW_OFS, be, wd, ack, fwd, rd);
    chk_val("cycles issued", 36'(cnt + 8'h01), 36'(n_seen));
    chk_val("bus", 36'(sel[23:16]), 36'(cfg_cycle.bus));
    chk_val("dev", 36'(sel[15:11]), 36'(cfg_cycle.dev));
    chk_val("func", 36'(sel[10:8]), 36'(cfg_cycle.func));
    chk_val("regnum", 36'(sel[6:2]), 36'(cfg_cycle.regnum));
    chk_val("be", 36'(be), 36'(cfg_cycle.be));
    chk_bit("write", wr, cfg_cycle.write);
    chk_bit("type1", t1, cfg_cycle.type1);
    chk_val("idsel", 36'(ids), 36'(cfg_cycle.idsel));
    if (wr) begin
      chk_val("wdata", 36'(wd), 36'(cfg_cycle.wdata));
    end
    chk_val("window data", 36'(wr ? 32'h0 : ({24'hC3A55A, 3'h0, sel[6:2]} & m)), 36'(rd));
  endtask : cfg_xfer

  task automatic t_reset();
    logic ack, fwd;
    logic [31:0] rd;
    mem_chk(36'h000000000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h000080000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000A0000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b1);
    mem_chk(36'h0000C0000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000E0000, 1'b1, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000F0000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h000F00000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h200000000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(HIGH_FW_BASE, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    io_op(1'b0, CFG_SELECT_OFS, 4'hF, 32'h0, ack, fwd, rd);
    chk_val("select reset", 36'(CFG_SELECT_RST), 36'(rd));
    io_op(1'b0, CFG_WINDOW_OFS, 4'hF, 32'h0, ack, fwd, rd);
    chk_bit("window disabled", 1'b1, fwd);
  endtask : t_reset

  task automatic t_map();
    load_attr(1'b0, 8'h01, 8'h02, 4'h1, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 36'h040000000);
    mem_chk(36'h00007FFFF, 1'b1, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h00009FFFF, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h0000C0000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h0000C0000, 1'b1, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000C4000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000C4000, 1'b1, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h0000C4000, 1'b1, 1'b1, HADC_TGT_DROP, 1'b0);
    mem_chk(36'h0000DFFFF, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000E0000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h0000E4000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000F0000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h0000FFFFF, 1'b1, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h0000F0000, 1'b0, 1'b1, HADC_TGT_DROP, 1'b0);
    mem_chk(36'h000EFFFFF, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h000F00000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(36'h020000000, 1'b1, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h080000000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(IRQ_ROUTER_BASE, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    mem_chk(HIGH_FW_BASE, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
    load_attr(1'b1, 8'h00, 8'h00, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, TOP_MAX);
    mem_chk(36'h00FFFFFFF, 1'b0, 1'b0, HADC_TGT_MEM, 1'b0);
    mem_chk(36'h020000000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b0);
  endtask : t_map

  task automatic t_mgmt();
    mgmt_mode_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    mem_chk(36'h0000A0000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b1);
    mgmt_mode_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    mem_chk(36'h0000A0000, 1'b0, 1'b0, HADC_TGT_PCI, 1'b1);
    load_attr(1'b1, 8'h00, 8'h00, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, TOP_MAX);
    mem_chk(36'h0000A0000, 1'b0, 1'b0, HADC_TGT_MEM, 1'b1);
  endtask : t_mgmt

  task automatic t_cfg();
    logic ack, fwd;
    logic [31:0] rd;
    cfg_xfer(1'b0, 32'hFF005273, 4'h3, 32'h0, 1'b0, 21'h000400);
    cfg_xfer(1'b1, 32'h8000000C, 4'hF, 32'h12345678, 1'b0, 21'h000001);
    cfg_xfer(1'b0, 32'h80016040, 4'hC, 32'h0, 1'b1, 21'h000000);
    io_op(1'b1, CFG_SELECT_OFS, 4'h3, 32'h80000000, ack, fwd, rd);
    chk_bit("narrow select forwarded", 1'b1, fwd);
    chk_bit("narrow select ack", 1'b0, ack);
    io_op(1'b0, CFG_SELECT_OFS, 4'hF, 32'h0, ack, fwd, rd);
    chk_val("select kept", 36'h080016040, 36'(rd));
    io_op(1'b0, 16'h0080, 4'hF, 32'h0, ack, fwd, rd);
    chk_bit("other io forwarded", 1'b1, fwd);
  endtask : t_cfg

  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    mgmt_mode_pin = 1'b0;
    attr_load = 1'b0;
    {isa_win_pci_in, addin_rd_in, addin_wr_in, ext_rd_in, ext_wr_in} = '0;
    {sys_rd_in, sys_wr_in, hole_pci_in, ext_mgmt_en_in, mgmt_open_in} = '0;
    installed_top_in = TOP_MAX;
    mem_req = '0;
    io_req = '0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_map();
    t_mgmt();
    t_cfg();
    close_out();
  end
endmodule : tb_host_address_decode_cfg_access
